// [tk_pkg.sv]
// Package with register map, field positions and reset values of the tick timer.
package tk_pkg;
	localparam int unsigned TK_CNT_W = 24;
	localparam int unsigned TK_REF_DIV = 8;
	localparam logic [7:0] TK_OFS_CTRL = 8'h00;
	localparam logic [7:0] TK_OFS_RELOAD = 8'h04;
	localparam logic [7:0] TK_OFS_CURRENT = 8'h08;
	localparam logic [7:0] TK_OFS_CALIB = 8'h0C;
	localparam logic [7:0] TK_OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] TK_OFS_IRQ_MASK = 8'h14;
	localparam int unsigned TK_BIT_ENABLE = 0;
	localparam int unsigned TK_BIT_REQ_EN = 1;
	localparam int unsigned TK_BIT_SRC = 2;
	localparam int unsigned TK_BIT_WRAP = 16;
	localparam int unsigned TK_BIT_NO_REFERENCE_INDICATOR = 31;
	localparam int unsigned TK_BIT_INEXACT = 30;
	localparam int unsigned TK_IRQ_W = 2;
	localparam int unsigned TK_IRQ_TICK = 0;
	localparam int unsigned TK_IRQ_WRAP = 1;
	localparam logic [2:0] TK_CTRL_RST = 3'h0;
	localparam logic [23:0] TK_RELOAD_RST = 24'h00_0000;
	localparam logic [23:0] TK_CNT_RST = 24'h00_0000;
	localparam logic [23:0] TK_CNT_ONE = 24'h00_0001;
	localparam logic [23:0] TK_CAL_DEFAULT = 24'h00_0000;
	localparam logic [1:0] TK_IRQ_RST = 2'h0;
	localparam logic [3:0] TK_SEL_WORD = 4'hF;
	localparam logic [31:0] TK_DAT_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {
		TK_BUS_IDLE = 2'b01,
		TK_BUS_ACK = 2'b10
	} tk_bus_state_t;
endpackage

// [tk_ref_div.sv]
// Reference tick source: one strobe every DIV core clocks.
`timescale 1ns/1ps
module tk_ref_div #(
	parameter int unsigned DIV = 8
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESET,
	// Advance only while the controller clock runs.
	input wire logic RUN,
	// One-cycle strobe at the reference rate.
	output logic STROBE
);
	localparam int unsigned W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	logic [W-1:0] div_q;
	logic strobe_q;
	wire at_last = (div_q == LAST);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			div_q <= '0;
			strobe_q <= 1'b0;
		end else begin
			if (RUN) begin
				div_q <= at_last ? '0 : div_q + W'(1);
			end
			strobe_q <= RUN & at_last;
		end
	end

	assign STROBE = strobe_q;
endmodule

// [tk_sync.sv]
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module tk_sync (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESET,
	// Level in and out.
	input wire logic ASYNC_IN,
	output logic SYNC_OUT
);
	logic meta_q;
	logic sync_q;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= ASYNC_IN;
			sync_q <= meta_q;
		end
	end

	assign SYNC_OUT = sync_q;
endmodule

// [tk_timer.sv]
// Down-counting periodic tick timer with a classic Wishbone register slave.
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
// Functional notes
// R1: The wrap flag and exception request fire only on the step from one to zero.
// R2: The reload field holds one up to all ones, and a zero reload is accepted but never ticks.
// R3: Software programs N minus one into reload for a tick every N counting clocks.
// R4: A current-value read returns the live count in bits 23:0 with zeros above.
// R5: Any write to the current value clears the count and the wrap flag and raises no request.
// R6: Calibration bit 31 reads zero, showing a reference clock at one eighth of the core clock.
// R7: Calibration bit 30 reads one, showing the millisecond calibration is inexact.
// R8: Calibration bits 23:0 return a fixed millisecond reload constant.
// R9: The counter moves only while the controller clock runs and holds its value when stopped.
// R10: Software uses full 32-bit word accesses only.
// R11: After reset software writes reload, then clears current, then writes control.
// R12: When enabled the count falls to zero, reloads on the next step, and keeps counting.
// R13: Control bit 16 shows a wrap since the last control read, and that read clears it.
// R14: Control bit 2 picks the source: zero the reference clock, one the core clock.
// R15: Control bit 1 gates whether reaching zero raises the tick exception request.
// R16: Control bit 0 enables counting when set and holds the count when clear.
module tk_timer
	import tk_pkg::*;
#(
	parameter logic [23:0] CAL_VALUE = TK_CAL_DEFAULT,
	parameter int unsigned REF_DIV = TK_REF_DIV
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESET,
	// Wishbone slave.
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Controller clock running, low while stopped for low power.
	input wire logic CLK_RUN,
	// Tick exception request and interrupt.
	output logic TICK_REQ,
	output logic IRQ
);
	tk_bus_state_t bus_q;
	tk_bus_state_t bus_d;
	logic [2:0] ctrl_q;
	logic [2:0] ctrl_d;
	logic [23:0] reload_q;
	logic [23:0] reload_d;
	logic [23:0] cnt_q;
	logic [23:0] cnt_d;
	logic wrap_q;
	logic wrap_d;
	logic [TK_IRQ_W-1:0] stat_q;
	logic [TK_IRQ_W-1:0] stat_d;
	logic [TK_IRQ_W-1:0] mask_q;
	logic [TK_IRQ_W-1:0] mask_d;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic ack_q;
	logic req_q;
	logic irq_q;
	logic run_s;
	logic ref_stb;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		hit = (adr == ofs);
	endfunction

	tk_sync u_run_sync (
		.CLK(CLK),
		.RESET(RESET),
		.ASYNC_IN(CLK_RUN),
		.SYNC_OUT(run_s)
	);

	tk_ref_div #(
		.DIV(REF_DIV)
	) u_ref_div (
		.CLK(CLK),
		.RESET(RESET),
		.RUN(run_s),
		.STROBE(ref_stb)
	);

	// Bus decode: a request is served once, in the idle state.
	wire req_take = WB_CYC_I & WB_STB_I & (bus_q == TK_BUS_IDLE);
	wire wr_take = req_take & WB_WE_I & (WB_SEL_I == TK_SEL_WORD);
	wire rd_take = req_take & ~WB_WE_I;
	wire sel_ctrl = hit(WB_ADR_I, TK_OFS_CTRL);
	wire sel_reload = hit(WB_ADR_I, TK_OFS_RELOAD);
	wire sel_cur = hit(WB_ADR_I, TK_OFS_CURRENT);
	wire sel_calib = hit(WB_ADR_I, TK_OFS_CALIB);
	wire sel_stat = hit(WB_ADR_I, TK_OFS_IRQ_STAT);
	wire sel_mask = hit(WB_ADR_I, TK_OFS_IRQ_MASK);
	wire wr_ctrl = wr_take & sel_ctrl;
	wire wr_reload = wr_take & sel_reload;
	wire wr_cur = wr_take & sel_cur;
	wire wr_stat = wr_take & sel_stat;
	wire wr_mask = wr_take & sel_mask;
	wire rd_ctrl = rd_take & sel_ctrl;

	// Counting step: enable, running controller clock, and the chosen source.
	wire src_tick = ctrl_q[TK_BIT_SRC] ? 1'b1 : ref_stb; // R14
	wire step = ctrl_q[TK_BIT_ENABLE] & run_s & src_tick; // R9 R16
	wire at_zero = (cnt_q == TK_CNT_RST);
	wire at_one = (cnt_q == TK_CNT_ONE);
	wire wrap_ev = step & at_one & ~wr_cur; // R1 R5
	wire tick_ev = wrap_ev & ctrl_q[TK_BIT_REQ_EN]; // R15

	// Register views for reads.
	wire [31:0] v_ctrl = {15'h0000, wrap_q, 13'h0000, ctrl_q}; // R13
	wire [31:0] v_reload = {8'h00, reload_q};
	wire [31:0] v_cur = {8'h00, cnt_q}; // R4
	wire [31:0] v_calib = {1'b0, 1'b1, 6'h00, CAL_VALUE}; // R6 R7 R8
	wire [31:0] v_stat = {{(32 - TK_IRQ_W){1'b0}}, stat_q};
	wire [31:0] v_mask = {{(32 - TK_IRQ_W){1'b0}}, mask_q};

	always_comb begin
		rdat_d = TK_DAT_ZERO;
		if (rd_take) begin
			if (sel_ctrl) begin
				rdat_d = v_ctrl;
			end else if (sel_reload) begin
				rdat_d = v_reload;
			end else if (sel_cur) begin
				rdat_d = v_cur;
			end else if (sel_calib) begin
				rdat_d = v_calib;
			end else if (sel_stat) begin
				rdat_d = v_stat;
			end else if (sel_mask) begin
				rdat_d = v_mask;
			end else begin
				rdat_d = TK_DAT_ZERO;
			end
		end
	end

	always_comb begin
		case (bus_q)
			TK_BUS_IDLE: begin
				bus_d = (WB_CYC_I & WB_STB_I) ? TK_BUS_ACK : TK_BUS_IDLE;
			end
			TK_BUS_ACK: begin
				bus_d = TK_BUS_IDLE;
			end
			default: begin
				bus_d = TK_BUS_IDLE;
			end
		endcase
	end

	// Control fields and reload value.
	assign ctrl_d = wr_ctrl ? WB_DAT_I[2:0] : ctrl_q; // R14 R15 R16
	assign reload_d = wr_reload ? WB_DAT_I[23:0] : reload_q; // R2

	// Counter: write clears, zero reloads, otherwise counts down.
	always_comb begin
		cnt_d = cnt_q;
		if (wr_cur) begin
			cnt_d = TK_CNT_RST; // R5
		end else if (step) begin
			if (at_zero) begin
				cnt_d = reload_q; // R12 R2
			end else begin
				cnt_d = cnt_q - TK_CNT_ONE; // R12
			end
		end
	end

	// Wrap flag: a wrap in the same cycle as a control read wins; a current write blocks the wrap.
	always_comb begin
		wrap_d = wrap_q;
		if (rd_ctrl | wr_cur) begin
			wrap_d = 1'b0; // R13 R5
		end
		if (wrap_ev) begin
			wrap_d = 1'b1; // R1 R13
		end
	end

	// Interrupt status: write one to clear, new events win.
	wire [TK_IRQ_W-1:0] ev_vec = {wrap_ev, tick_ev};
	wire [TK_IRQ_W-1:0] clr_vec = wr_stat ? WB_DAT_I[TK_IRQ_W-1:0] : '0;
	assign stat_d = (stat_q & ~clr_vec) | ev_vec;
	assign mask_d = wr_mask ? WB_DAT_I[TK_IRQ_W-1:0] : mask_q;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			bus_q <= TK_BUS_IDLE;
			ack_q <= 1'b0;
			rdat_q <= TK_DAT_ZERO;
		end else begin
			bus_q <= bus_d;
			ack_q <= req_take;
			rdat_q <= rdat_d;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl_q <= TK_CTRL_RST;
			reload_q <= TK_RELOAD_RST;
			cnt_q <= TK_CNT_RST;
			wrap_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			reload_q <= reload_d;
			cnt_q <= cnt_d;
			wrap_q <= wrap_d;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			stat_q <= TK_IRQ_RST;
			mask_q <= TK_IRQ_RST;
			req_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			req_q <= tick_ev; // R15 R1
			irq_q <= |(stat_d & mask_d);
		end
	end

	assign WB_DAT_O = rdat_q;
	assign WB_ACK_O = ack_q;
	assign TICK_REQ = req_q;
	assign IRQ = irq_q;
endmodule

// [tk_timer_chk.sv]
// Checker for the tick timer ports.
`timescale 1ns/1ps
module tk_timer_chk
	import tk_pkg::*;
(
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESET,
	// Bus.
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Tick side.
	input wire logic CLK_RUN,
	input wire logic TICK_REQ,
	input wire logic IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_take;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_acc(logic w, logic [7:0] a);
		s_take ##0 WB_WE_I == w && WB_ADR_I == a && WB_SEL_I == TK_SEL_WORD;
	endsequence
	property p_ack; s_take |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_cal; s_acc(0, TK_OFS_CALIB) |=> WB_DAT_O[31:24] == 8'h40; endproperty
	a_cal: assert property (p_cal) else $error("calib flags");
	property p_cur; s_acc(0, TK_OFS_CURRENT) |=> WB_DAT_O[31:24] == 8'h00; endproperty
	a_cur: assert property (p_cur) else $error("current top");
	property p_ctl; s_acc(0, TK_OFS_CTRL) |=> WB_DAT_O[15:3] == 13'h0000; endproperty
	a_ctl: assert property (p_ctl) else $error("control gap");
	property p_clr; s_acc(1, TK_OFS_CURRENT) |=> !TICK_REQ [*2]; endproperty
	a_clr: assert property (p_clr) else $error("tick on clear");
	property p_one; TICK_REQ |=> !TICK_REQ; endproperty
	a_one: assert property (p_one) else $error("tick width");
	property p_frz; !CLK_RUN [*4] |-> !TICK_REQ; endproperty
	a_frz: assert property (p_frz) else $error("tick while stopped");
	property p_irq; s_acc(1, TK_OFS_IRQ_MASK) ##0 WB_DAT_I[1:0] == 2'h0 |-> ##2 !IRQ; endproperty
	a_irq: assert property (p_irq) else $error("irq masked");
endmodule
bind tk_timer tk_timer_chk u_chk (.CLK(CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
	.WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CLK_RUN(CLK_RUN),
	.TICK_REQ(TICK_REQ), .IRQ(IRQ));

// [tk_timer_tb.sv]
// Self-checking bench for the tick timer.
`timescale 1ns/1ps
module tk_timer_tb
	import tk_pkg::*;
;
	localparam logic [23:0] CAL = 24'h01_2345;
	logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, run = 1'h1;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000, r, dat_o;
	logic ack, tick, irq;
	int miscompares = 0, total_checks = 0, k;
	tk_timer #(.CAL_VALUE(CAL)) uut (.CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .CLK_RUN(run), .TICK_REQ(tick), .IRQ(irq));
	initial begin
		forever #25 clk = ~clk;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		@(posedge clk);
		while (ack !== 1'h1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk(ack, 32'h0000_0001);
		r = dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'h1, a, d, TK_SEL_WORD);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, TK_DAT_ZERO, TK_SEL_WORD);
		chk(r, e);
	endtask
	task cnt(input int n);
		k = 0;
		repeat (n) begin
			@(negedge clk);
			if (tick === 1'h1) k++;
		end
		@(posedge clk);
	endtask
	task setup(input logic [23:0] rl, input logic [31:0] c);
		wr(TK_OFS_RELOAD, {8'h00, rl});
		wr(TK_OFS_CURRENT, 32'h0000_0000);
		wr(TK_OFS_CTRL, c);
	endtask
	task t_cal;
		rd(TK_OFS_CALIB, {8'h40, CAL});
		rd(8'h18, 32'h0000_0000);
		$display("calib end");
	endtask
	task t_tick;
		wr(TK_OFS_IRQ_MASK, 32'h0000_0003);
		setup(24'h00_0002, 32'h0000_0007);
		cnt(30);
		chk(k, 32'h0000_000A);
		chk(irq, 32'h0000_0001);
		wr(TK_OFS_CTRL, 32'h0000_0000);
		rd(TK_OFS_CTRL, 32'h0001_0000);
		rd(TK_OFS_CTRL, 32'h0000_0000);
		wr(TK_OFS_IRQ_STAT, 32'h0000_0003);
		rd(TK_OFS_IRQ_STAT, 32'h0000_0000);
		chk(irq, 32'h0000_0000);
		$display("tick end");
	endtask
	task t_zero;
		setup(24'h00_0000, 32'h0000_0007);
		cnt(40);
		chk(k, 32'h0000_0000);
		rd(TK_OFS_CTRL, 32'h0000_0007);
		$display("zero end");
	endtask
	task t_hold;
		setup(24'hFF_FFFF, 32'h0000_0005);
		wr(TK_OFS_CTRL, 32'h0000_0004);
		wb(1'h0, TK_OFS_CURRENT, TK_DAT_ZERO, TK_SEL_WORD);
		rd(TK_OFS_CURRENT, r);
		wb(1'h1, TK_OFS_RELOAD, 32'h0000_0005, 4'h3);
		rd(TK_OFS_RELOAD, 32'h00FF_FFFF);
		wr(TK_OFS_CURRENT, 32'hFFFF_FFFF);
		rd(TK_OFS_CURRENT, 32'h0000_0000);
		$display("hold end");
	endtask
	task t_ref;
		wr(TK_OFS_IRQ_MASK, 32'h0000_0000);
		setup(24'h00_0001, 32'h0000_0003);
		cnt(64);
		chk(k, 32'h0000_0004);
		rd(TK_OFS_IRQ_STAT, 32'h0000_0003);
		chk(irq, 32'h0000_0000);
		run <= 1'h0;
		cnt(4);
		wb(1'h0, TK_OFS_CURRENT, TK_DAT_ZERO, TK_SEL_WORD);
		cnt(64);
		chk(k, 32'h0000_0000);
		rd(TK_OFS_CURRENT, r);
		run <= 1'h1;
		$display("ref end");
	endtask
	task end_sim;
		$display("checks %0d bad %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#500000;
		miscompares++;
		end_sim;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		t_cal;
		t_tick;
		t_zero;
		t_hold;
		t_ref;
		end_sim;
	end
endmodule
